/* File: rtl/tcg_in_sync.sv */
// Pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module tcg_in_sync (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);
  import tcg_pkg::*;

  logic [SYNC_DEPTH-1:0] sync_r;
  logic [SYNC_DEPTH-1:0] sync_nxt;
  logic                  lvl_r;
  logic                  lvl_nxt;
  logic                  rise_r;
  logic                  rise_nxt;
  logic                  fall_r;
  logic                  fall_nxt;

  // First stage feeds only the second stage
  always_comb begin
    sync_nxt = {sync_r[1], sync_r[0], pin_in};
    lvl_nxt  = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
    rise_nxt = lvl_nxt & ~lvl_r;
    fall_nxt = ~lvl_nxt & lvl_r;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_r <= '0;
      lvl_r  <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign lvl  = lvl_r;
  assign rise = rise_r;
  assign fall = fall_r;
endmodule : tcg_in_sync
`default_nettype wire

/* File: rtl/tcg_pkg.sv */
// Constants for the single-channel compare, gated and capture/compare timer
// Functional notes
// - Compare mode: match interrupts unless input-only selected, count keeps running
// - Compare mode: match inverts the timer output
// - All-ones count wraps to zero, keeps counting
// - Output always to events; pin when enabled
// - Compare mode counts the clock selected in control 2, ignores input
// - Gated mode counts only while input active
// - Gated deassertion interrupts and sets input flag
// - Gated reload: interrupt, count to one, toggle
// - Gated start count used on first pass only
// - Gated interrupts selectable: both, deassert, reload
// - Capture/compare holds count until first edge
// - First capture/compare edge raises no interrupt
// - Later edge captures, interrupts, flags, restarts
// - Compare reached without capture: interrupt, clear flag
// - Capture/compare interrupts selectable: both, capture, reload
package tcg_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 4;
  // Register offsets
  localparam logic [AW-1:0] ADDR_CTRL0   = 4'h0;
  localparam logic [AW-1:0] ADDR_CTRL1   = 4'h1;
  localparam logic [AW-1:0] ADDR_CTRL2   = 4'h2;
  localparam logic [AW-1:0] ADDR_COUNT   = 4'h3;
  localparam logic [AW-1:0] ADDR_RELOAD  = 4'h4;
  localparam logic [AW-1:0] ADDR_CAPTURE = 4'h5;
  // timer_control_zero fields
  localparam int unsigned C0_FLAG_BIT  = 0;
  localparam int unsigned C0_CFG_LSB   = 1;
  localparam int unsigned C0_MODE3_BIT = 3;
  // Control register 1 fields
  localparam int unsigned C1_MODE_LSB  = 0;
  localparam int unsigned C1_PRES_LSB  = 3;
  localparam int unsigned C1_POL_BIT   = 6;
  localparam int unsigned C1_EN_BIT    = 7;
  // Control register 2 fields
  localparam int unsigned C2_CLKSRC_BIT = 0;
  localparam int unsigned C2_ALTEN_BIT  = 1;
  // Reset values and count constants
  localparam logic [DW-1:0] COUNT_RST  = 16'h0000;
  localparam logic [DW-1:0] RELOAD_RST = 16'hffff;
  localparam logic [DW-1:0] COUNT_ONE  = 16'h0001;
  localparam logic [DW-1:0] COUNT_ALL1 = 16'hffff;
  // count_mode_select codes
  localparam logic [3:0] MODE_COMPARE = 4'h5;
  localparam logic [3:0] MODE_GATED   = 4'h6;
  localparam logic [3:0] MODE_CAPCMP  = 4'h7;
  // irq_source_config codes
  localparam logic [1:0] CFG_BOTH    = 2'h0;
  localparam logic [1:0] CFG_INPUT   = 2'h2;
  localparam logic [1:0] CFG_RELOAD  = 2'h3;
  localparam int unsigned SYNC_DEPTH = 3;
  typedef enum logic [1:0] {
    TCG_CC_IDLE = 2'b00,
    TCG_CC_WAIT = 2'b01,
    TCG_CC_RUN  = 2'b11
  } tcg_cc_e;
endpackage : tcg_pkg

/* File: rtl/tcg_timer.sv */
// Timer channel: compare, gated and capture/compare modes with register port
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tcg_timer (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic [tcg_pkg::AW-1:0] reg_addr,
  input  wire logic [tcg_pkg::DW-1:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [tcg_pkg::DW-1:0] reg_rdata,
  input  wire logic               tmr_in0,
  input  wire logic               tmr_ext_clk,
  output logic                    tmr_evt_out,
  output logic                    tmr_pin_o,
  output logic                    tmr_pin_oe,
  output logic                    tmr_irq,
  output logic                    input_event_flag
);
  import tcg_pkg::*;

  logic [1:0]    irq_source_config_r, irq_source_config_nxt;
  logic          mode3_r, mode3_nxt;
  logic [2:0]    mode_lo_r, mode_lo_nxt;
  logic [2:0]    pres_r, pres_nxt;
  logic          input_polarity_select_r, input_polarity_select_nxt;
  logic          en_r, en_nxt;
  logic          clk_src_r, clk_src_nxt;
  logic          alt_en_r, alt_en_nxt;
  logic [DW-1:0] count_r, count_nxt;
  logic [DW-1:0] reload_r, reload_nxt;
  logic [DW-1:0] capture_r, capture_nxt;
  logic          flag_r, flag_nxt;
  logic          out_r, out_nxt;
  logic          irq_r, irq_nxt;
  logic [6:0]    pre_cnt_r, pre_cnt_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  tcg_cc_e       cc_state_r, cc_state_nxt;

  logic [3:0] count_mode_select;
  logic       in_lvl, in_rise, in_fall;
  logic       ext_rise;
  logic       src_tick, run_ok, ptick, match;
  logic       gate_act, gate_off, sel_edge;
  logic       ev_input, ev_reload;
  logic       is_cmp, is_gate, is_cc;
  logic       wr_count;

  // Divide ratio is two to the prescale setting
  function automatic logic [6:0] pres_limit(input logic [2:0] p);
    logic [7:0] lim;
    lim = (8'h01 << p) - 8'h01;
    return lim[6:0];
  endfunction : pres_limit

  function automatic logic wr_hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    return reg_wr && (a == off);
  endfunction : wr_hit

  tcg_in_sync u_in0_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_in  (tmr_in0),
    .lvl     (in_lvl),
    .rise    (in_rise),
    .fall    (in_fall)
  );

  tcg_in_sync u_extclk_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_in  (tmr_ext_clk),
    .lvl     (),
    .rise    (ext_rise),
    .fall    ()
  );

  // Top mode bit lives in control zero, low bits in control one
  assign count_mode_select = {mode3_r, mode_lo_r};
  assign is_cmp   = (count_mode_select == MODE_COMPARE);
  assign is_gate  = (count_mode_select == MODE_GATED);
  assign is_cc    = (count_mode_select == MODE_CAPCMP);
  assign gate_act = (in_lvl == input_polarity_select_r);
  assign gate_off = input_polarity_select_r ? in_fall : in_rise;
  assign sel_edge = input_polarity_select_r ? in_rise : in_fall;
  assign match    = (count_r == reload_r);
  // Strobe read directly so this net follows reg_wr
  assign wr_count = reg_wr && (reg_addr == ADDR_COUNT);

  // Compare mode never looks at the input pin
  always_comb begin
    src_tick = clk_src_r ? ext_rise : 1'b1;
    if (is_cmp) begin
      run_ok = 1'b1;
    end else if (is_gate) begin
      run_ok = gate_act;
    end else if (is_cc) begin
      run_ok = (cc_state_r == TCG_CC_RUN);
    end else begin
      run_ok = 1'b0;
    end
    // At or past the limit, so a smaller prescale set mid-run cannot overshoot
    ptick = en_r && run_ok && src_tick && (pre_cnt_r >= pres_limit(pres_r));
  end

  always_comb begin
    cc_state_nxt = cc_state_r;
    if (!en_r || !is_cc) begin
      cc_state_nxt = TCG_CC_IDLE;
    end else begin
      unique case (cc_state_r)
        TCG_CC_IDLE: cc_state_nxt = TCG_CC_WAIT;
        TCG_CC_WAIT: if (sel_edge) cc_state_nxt = TCG_CC_RUN;
        TCG_CC_RUN:  cc_state_nxt = TCG_CC_RUN;
        default:     cc_state_nxt = TCG_CC_IDLE;
      endcase
    end
  end

  always_comb begin
    irq_source_config_nxt     = irq_source_config_r;
    mode3_nxt                 = mode3_r;
    mode_lo_nxt               = mode_lo_r;
    pres_nxt                  = pres_r;
    input_polarity_select_nxt = input_polarity_select_r;
    en_nxt                    = en_r;
    clk_src_nxt               = clk_src_r;
    alt_en_nxt                = alt_en_r;
    reload_nxt                = reload_r;
    capture_nxt               = capture_r;
    count_nxt                 = count_r;
    flag_nxt                  = flag_r;
    out_nxt                   = out_r;
    pre_cnt_nxt               = pre_cnt_r;
    ev_input                  = 1'b0;
    ev_reload                 = 1'b0;
    if (wr_hit(reg_addr, ADDR_CTRL0)) begin
      irq_source_config_nxt = reg_wdata[C0_CFG_LSB +: 2];
      mode3_nxt             = reg_wdata[C0_MODE3_BIT];
    end
    if (wr_hit(reg_addr, ADDR_CTRL1)) begin
      mode_lo_nxt               = reg_wdata[C1_MODE_LSB +: 3];
      pres_nxt                  = reg_wdata[C1_PRES_LSB +: 3];
      input_polarity_select_nxt = reg_wdata[C1_POL_BIT];
      en_nxt                    = reg_wdata[C1_EN_BIT];
    end
    if (wr_hit(reg_addr, ADDR_CTRL2)) begin
      clk_src_nxt = reg_wdata[C2_CLKSRC_BIT];
      alt_en_nxt  = reg_wdata[C2_ALTEN_BIT];
    end
    if (wr_hit(reg_addr, ADDR_RELOAD)) begin
      reload_nxt = reg_wdata;
    end
    if (wr_hit(reg_addr, ADDR_CAPTURE)) begin
      capture_nxt = reg_wdata;
    end
    // Prescaler restarts while the timer is disabled and holds while counting pauses
    if (!en_r) begin
      pre_cnt_nxt = 7'h00;
      out_nxt     = input_polarity_select_r;
    end else if (run_ok && src_tick) begin
      pre_cnt_nxt = ptick ? 7'h00 : pre_cnt_r + 7'h01;
    end
    if (en_r) begin
      if (is_cmp && ptick) begin
        count_nxt = count_r + COUNT_ONE;
        if (match) begin
          out_nxt   = ~out_r;
          ev_reload = 1'b1;
        end
      end else if (is_gate) begin
        if (gate_off) begin
          ev_input = 1'b1;
          flag_nxt = 1'b1;
        end else if (ptick && match) begin
          count_nxt = COUNT_ONE;
          out_nxt   = ~out_r;
          ev_reload = 1'b1;
          flag_nxt  = 1'b0;
        end else if (ptick) begin
          count_nxt = count_r + COUNT_ONE;
        end
      end else if (is_cc && cc_state_r == TCG_CC_RUN) begin
        // Capture beats a coincident compare match
        if (sel_edge) begin
          capture_nxt = count_r;
          count_nxt   = COUNT_ONE;
          ev_input    = 1'b1;
          flag_nxt    = 1'b1;
          pre_cnt_nxt = 7'h00;
        end else if (ptick && match) begin
          count_nxt = COUNT_ONE;
          ev_reload = 1'b1;
          flag_nxt  = 1'b0;
        end else if (ptick) begin
          count_nxt = count_r + COUNT_ONE;
        end
      end
    end
    // Software load of the count overrides a same-cycle tick
    if (wr_count) begin
      count_nxt = reg_wdata;
    end
    // Reload-type events from compare mode obey the same selection
    irq_nxt = (ev_input && irq_source_config_r != CFG_RELOAD) ||
              (ev_reload && irq_source_config_r != CFG_INPUT);
  end

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL0:   rdata_nxt = {12'h000, mode3_r, irq_source_config_r, flag_r};
        ADDR_CTRL1:   rdata_nxt = {8'h00, en_r, input_polarity_select_r, pres_r, mode_lo_r};
        ADDR_CTRL2:   rdata_nxt = {14'h0000, alt_en_r, clk_src_r};
        ADDR_COUNT:   rdata_nxt = count_r;
        ADDR_RELOAD:  rdata_nxt = reload_r;
        ADDR_CAPTURE: rdata_nxt = capture_r;
        default:      rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_source_config_r     <= CFG_BOTH;
      mode3_r                 <= 1'b0;
      mode_lo_r               <= 3'h0;
      pres_r                  <= 3'h0;
      input_polarity_select_r <= 1'b0;
      en_r                    <= 1'b0;
      clk_src_r               <= 1'b0;
      alt_en_r                <= 1'b0;
      count_r                 <= COUNT_RST;
      reload_r                <= RELOAD_RST;
      capture_r               <= COUNT_RST;
      flag_r                  <= 1'b0;
      out_r                   <= 1'b0;
      irq_r                   <= 1'b0;
      pre_cnt_r               <= 7'h00;
      rdata_r                 <= '0;
      cc_state_r              <= TCG_CC_IDLE;
    end else begin
      irq_source_config_r     <= irq_source_config_nxt;
      mode3_r                 <= mode3_nxt;
      mode_lo_r               <= mode_lo_nxt;
      pres_r                  <= pres_nxt;
      input_polarity_select_r <= input_polarity_select_nxt;
      en_r                    <= en_nxt;
      clk_src_r               <= clk_src_nxt;
      alt_en_r                <= alt_en_nxt;
      count_r                 <= count_nxt;
      reload_r                <= reload_nxt;
      capture_r               <= capture_nxt;
      flag_r                  <= flag_nxt;
      out_r                   <= out_nxt;
      irq_r                   <= irq_nxt;
      pre_cnt_r               <= pre_cnt_nxt;
      rdata_r                 <= rdata_nxt;
      cc_state_r              <= cc_state_nxt;
    end
  end

  assign reg_rdata        = rdata_r;
  assign tmr_evt_out      = out_r;
  assign tmr_pin_o        = out_r;
  assign tmr_pin_oe       = alt_en_r;
  assign tmr_irq          = irq_r;
  assign input_event_flag = flag_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  disabled_hold_a: assert property (
    !en_r && !wr_count |=> count_r == $past(count_r) && !tmr_irq)
    else $error("disabled timer moved count or interrupted");
  cmp_toggle_a: assert property (
    en_r && is_cmp && ptick && match |=> tmr_evt_out != $past(tmr_evt_out))
    else $error("compare match did not toggle output");
  cmp_continue_a: assert property (
    en_r && is_cmp && ptick && match && !wr_count |=> count_r == $past(count_r) + COUNT_ONE)
    else $error("compare match reset the count");
  cmp_wrap_a: assert property (
    en_r && is_cmp && ptick && count_r == COUNT_ALL1 && !wr_count |=> count_r == COUNT_RST)
    else $error("all-ones count did not wrap to zero");
  cmp_src_a: assert property (
    en_r && is_cmp && !clk_src_r && pres_r == 3'h0 |-> ptick)
    else $error("compare mode missed an internal tick");
  pin_route_a: assert property (
    reg_wr && reg_addr == ADDR_CTRL2
      |=> tmr_pin_oe == $past(reg_wdata[C2_ALTEN_BIT]) && tmr_pin_o == tmr_evt_out)
    else $error("timer output routing wrong");
  gate_hold_a: assert property (
    en_r && is_gate && !gate_act && !gate_off && !wr_count |=> $stable(count_r))
    else $error("gated count moved while input inactive");
  gate_deassert_a: assert property (
    en_r && is_gate && gate_off && irq_source_config_r != CFG_RELOAD
      |=> tmr_irq && input_event_flag)
    else $error("gate deassertion not reported");
  gate_reload_a: assert property (
    en_r && is_gate && !gate_off && ptick && match && !wr_count
      |=> count_r == COUNT_ONE && tmr_evt_out != $past(tmr_evt_out))
    else $error("gated reload wrong");
  cfg_filter_a: assert property (
    irq_source_config_r == CFG_INPUT && !ev_input |=> !tmr_irq)
    else $error("reload interrupt leaked in input-only setting");
  cc_first_a: assert property (
    en_r && is_cc && cc_state_r == TCG_CC_WAIT && sel_edge
      |=> !tmr_irq && cc_state_r == TCG_CC_RUN)
    else $error("first edge misbehaved");
  cc_capture_a: assert property (
    en_r && is_cc && cc_state_r == TCG_CC_RUN && sel_edge && !wr_count
      |=> capture_r == $past(count_r) && count_r == COUNT_ONE && input_event_flag)
    else $error("capture edge handled wrongly");
  cc_reload_a: assert property (
    en_r && is_cc && cc_state_r == TCG_CC_RUN && !sel_edge && ptick && match && !wr_count
      |=> count_r == COUNT_ONE && !input_event_flag)
    else $error("compare restart handled wrongly");

  cmp_match_c: cover property (en_r && is_cmp && ptick && match);
  cc_capture_c: cover property (is_cc && cc_state_r == TCG_CC_RUN && sel_edge);
  gate_off_c: cover property (en_r && is_gate && gate_off ##1 tmr_irq);
endmodule : tcg_timer
`default_nettype wire

/* File: verif/tcg_far_model.sv */
// Far-side model: timer input 0 source, external clock source and pin load
`timescale 1ns/1ps
`default_nettype none
module tcg_far_model (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic in_req,
  input  wire logic ext_run,
  input  wire logic tmr_pin_o,
  input  wire logic tmr_pin_oe,
  output logic      tmr_in0,
  output logic      tmr_ext_clk,
  output logic      pin_wire
);
  logic [1:0] div_r;
  // Input moves just after an edge, so edge spacing is exact in cycles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tmr_in0 <= 1'b0;
      div_r   <= 2'h0;
    end else begin
      tmr_in0 <= in_req;
      div_r   <= ext_run ? div_r + 2'h1 : 2'h0;
    end
  end
  // Stands still low unless asked to run
  assign tmr_ext_clk = div_r[1];
  // Pull-up on the pin while the timer leaves it undriven
  assign pin_wire = tmr_pin_oe ? tmr_pin_o : 1'b1;
endmodule : tcg_far_model
`default_nettype wire

/* File: verif/tcg_timer_tb.sv */
// Register-level bench for the timer channel
`timescale 1ns/1ps
`default_nettype none
module tcg_timer_tb;
  import tcg_pkg::*;
  logic          clk_sys   = 1'b0;
  logic          rstn      = 1'b0;
  logic [AW-1:0] reg_addr  = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic          reg_wr    = 1'b0;
  logic          reg_rd    = 1'b0;
  logic          in_req    = 1'b0;
  logic          ext_run   = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic          tmr_in0, tmr_ext_clk, pin_wire;
  logic          tmr_evt_out, tmr_pin_o, tmr_pin_oe, tmr_irq, input_event_flag;
  logic [DW-1:0] v;
  logic [DW-1:0] g_exp [4] = '{16'h0003, 16'h0003, 16'h0001, 16'h0002};
  logic [1:0]    c_cfg [3] = '{2'h0, 2'h2, 2'h3};
  logic [DW-1:0] c_exp [3] = '{16'h0002, 16'h0001, 16'h0001};
  int            miscompares = 0;
  int            checks = 0;
  int            irq_cnt = 0;

  tcg_timer dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr_in0(tmr_in0),
    .tmr_ext_clk(tmr_ext_clk), .tmr_evt_out(tmr_evt_out), .tmr_pin_o(tmr_pin_o),
    .tmr_pin_oe(tmr_pin_oe), .tmr_irq(tmr_irq), .input_event_flag(input_event_flag));
  tcg_far_model u_far (.clk_sys(clk_sys), .rstn(rstn), .in_req(in_req), .ext_run(ext_run),
    .tmr_pin_o(tmr_pin_o), .tmr_pin_oe(tmr_pin_oe), .tmr_in0(tmr_in0),
    .tmr_ext_clk(tmr_ext_clk), .pin_wire(pin_wire));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // Pulse counter; cleared by the tests only while the line is quiet
  always @(posedge clk_sys) begin
    if (tmr_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  task automatic end_of_test();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rdc

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cycles

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (tmr_irq !== 1'b1) begin
      n++;
      if (n > lim) begin
        miscompares++;
        $display("ERROR at %0t: no interrupt", $time);
        end_of_test();
      end
      @(posedge clk_sys);
    end
  endtask : wait_irq

  initial begin
    #200000;
    miscompares++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rdc(ADDR_COUNT, 16'h0000);
    rdc(ADDR_RELOAD, 16'hffff);
    rdc(ADDR_CAPTURE, 16'h0000);
    rdc(ADDR_CTRL1, 16'h0000);
    #20 check(reg_rdata, 16'h0000);
    check(16'(tmr_pin_oe), 16'h0000);
    wr(4'h9, 16'hbeef);
    rdc(4'h9, 16'h0000);
    wr(ADDR_CTRL0, 16'h0001);
    rdc(ADDR_CTRL0, 16'h0000);
    // Top mode bit set: code 13 is not a counting mode here
    wr(ADDR_CTRL0, 16'h0008);
    rdc(ADDR_CTRL0, 16'h0008);
    wr(ADDR_CTRL1, 16'h0085);
    cycles(5);
    rdc(ADDR_COUNT, 16'h0000);
    // Compare mode; input and external clock toggle but must not matter
    wr(ADDR_CTRL1, 16'h0005);
    wr(ADDR_CTRL2, 16'h0002);
    wr(ADDR_CTRL0, 16'h0000);
    wr(ADDR_COUNT, 16'hffff);
    wr(ADDR_RELOAD, 16'h0000);
    ext_run <= 1'b1;
    in_req  <= 1'b1;
    irq_cnt = 0;
    wr(ADDR_CTRL1, 16'h0085);
    wait_irq(20);
    rdc(ADDR_COUNT, 16'h0003);
    check(16'(irq_cnt), 16'h0001);
    check(16'(tmr_evt_out), 16'h0001);
    check(16'(pin_wire), 16'h0001);
    wr(ADDR_CTRL1, 16'h0005);
    wr(ADDR_COUNT, 16'h1234);
    irq_cnt = 0;
    cycles(20);
    rdc(ADDR_COUNT, 16'h1234);
    check(16'(irq_cnt), 16'h0000);
    check(16'(pin_wire), 16'h0000);
    wr(ADDR_CTRL2, 16'h0000);
    cycles(1);
    check(16'(pin_wire), 16'h0001);
    check(16'(tmr_evt_out), 16'h0000);
    ext_run <= 1'b0;
    in_req  <= 1'b0;
    // Gated mode: start 5, reload 8, gate held about 14 ticks
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL1, 16'h0046);
      wr(ADDR_CTRL0, 16'(i) << C0_CFG_LSB);
      wr(ADDR_COUNT, 16'h0005);
      wr(ADDR_RELOAD, 16'h0008);
      wr(ADDR_CTRL1, 16'h00c6);
      irq_cnt = 0;
      cycles(10);
      rdc(ADDR_COUNT, 16'h0005);
      in_req <= 1'b1;
      cycles(14);
      in_req <= 1'b0;
      cycles(10);
      check(16'(irq_cnt), g_exp[i]);
      check(16'(input_event_flag), 16'h0001);
      check(16'(tmr_evt_out), 16'h0001);
    end
    // Capture/compare: edges 40 cycles apart, then run to the compare value
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL1, 16'h0047);
      wr(ADDR_COUNT, 16'h0001);
      wr(ADDR_CTRL2, 16'h0000);
      wr(ADDR_CTRL0, 16'(c_cfg[i]) << C0_CFG_LSB);
      wr(ADDR_RELOAD, 16'h0080);
      wr(ADDR_CAPTURE, 16'h0000);
      wr(ADDR_CTRL1, 16'h00c7);
      irq_cnt = 0;
      cycles(10);
      rdc(ADDR_COUNT, 16'h0001);
      in_req <= 1'b1;
      cycles(20);
      in_req <= 1'b0;
      cycles(20);
      in_req <= 1'b1;
      check(16'(irq_cnt), 16'h0000);
      cycles(10);
      rd(ADDR_CAPTURE, v);
      check(16'(v >= 16'd39 && v <= 16'd42), 16'h0001);
      check(16'(input_event_flag), 16'h0001);
      cycles(150);
      check(16'(irq_cnt), c_exp[i]);
      check(16'(input_event_flag), 16'h0000);
      in_req <= 1'b0;
    end
    end_of_test();
  end
endmodule : tcg_timer_tb
`default_nettype wire
